/* dv/cpu_model.sv */
/* cpu core stand-in: gate bit, select field and the one-cycle halt strobe.
   assumes the bench commands it at falling edges. */
`timescale 1ns/1ps
module cpu_model (
    // clock
    input wire clk_i,
    // bench commands
    input wire go_i,
    input wire gate_i,
    input wire [2:0] sel_i,
    // towards the controller
    output reg halt_o = 1'b0,
    output reg gate_o = 1'b0,
    output reg [2:0] sel_o = 3'h0
);
    // outputs move on the falling edge, clear of the sampling edge
    always @(negedge clk_i) begin
        halt_o <= go_i;
        gate_o <= gate_i;
        sel_o <= sel_i;
    end
endmodule // cpu_model

/* dv/sleep_ctl_sva.sv */
/* port assertions for the sleep controller.
   assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module sleep_ctl_sva #(
    parameter NPER = 8
) (
    input wire MCLK_I, input wire RST_N_I, input wire HALT_EXEC_I, input wire SLEEP_GATE_BIT_I,
    input wire [2:0] SLEEP_SELECT_FIELD_I, input wire ADC_ENABLED_I, input wire COMPARATOR_OFF_BIT_I,
    input wire [NPER-1:0] CLOCK_STOP_REGISTER_I, input wire [NPER-1:0] PERIPH_CLK_EN_O,
    input wire [NPER-1:0] PERIPH_ACCESS_EN_O, input wire CPU_CLK_EN_O, input wire FLASH_CLK_EN_O,
    input wire IO_CLK_EN_O, input wire ADC_CLK_EN_O, input wire ASYNC_TIMER_CLOCK_EN_O,
    input wire MAIN_OSC_EN_O, input wire COMPARATOR_POWER_O, input wire CPU_HALT_O,
    input wire ADC_START_O, input wire WAKE_IRQ_O, input wire WAKE_RESET_O,
    input wire [2:0] SLEEP_MODE_O, input wire SLEEPING_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // a halt counts only while the core is fully awake
    wire take = HALT_EXEC_I && SLEEP_GATE_BIT_I && !CPU_HALT_O;
    wire [2:0] sel = SLEEP_SELECT_FIELD_I;
    AST_GATE_AND_HALT: assert property (!SLEEPING_O && !(HALT_EXEC_I && SLEEP_GATE_BIT_I)
        |=> !SLEEPING_O) else $error("sleep entered without gate and halt");
    AST_IDLE_CLOCKS: assert property (SLEEPING_O && SLEEP_MODE_O == 3'h0 |-> !CPU_CLK_EN_O
        && !FLASH_CLK_EN_O && IO_CLK_EN_O && ADC_CLK_EN_O) else $error("idle gating wrong");
    AST_ADC_QUIET_CLOCKS: assert property (SLEEPING_O && SLEEP_MODE_O == 3'h1 |-> !IO_CLK_EN_O
        && !CPU_CLK_EN_O && !FLASH_CLK_EN_O && ADC_CLK_EN_O) else $error("adc sleep gating wrong");
    AST_PWR_DOWN_CLOCKS: assert property (SLEEPING_O && SLEEP_MODE_O == 3'h2 |-> !MAIN_OSC_EN_O
        && !IO_CLK_EN_O && !ADC_CLK_EN_O && !ASYNC_TIMER_CLOCK_EN_O) else $error("pd gating");
    AST_STANDBY_OSC: assert property (SLEEPING_O && SLEEP_MODE_O == 3'h6
        |-> MAIN_OSC_EN_O && !IO_CLK_EN_O) else $error("standby oscillator wrong");
    AST_RESERVED_AWAKE: assert property (take && sel[2:1] == 2'h2
        |=> !SLEEPING_O ##1 !SLEEPING_O) else $error("reserved code slept");
    AST_ADC_AUTOSTART: assert property (take && ADC_ENABLED_I && sel[2:1] == 2'h0
        |=> ADC_START_O) else $error("no conversion start");
    AST_WAKE_HOLD: assert property (WAKE_IRQ_O |-> CPU_HALT_O [*8] ##[1:60] !CPU_HALT_O)
        else $error("cpu hold after wake wrong");
    AST_ACCESS_BLOCK: assert property (PERIPH_ACCESS_EN_O == ~CLOCK_STOP_REGISTER_I)
        else $error("peripheral access enable wrong");
    AST_STOP_ACTIVE: assert property (!CPU_HALT_O |-> PERIPH_CLK_EN_O == ~CLOCK_STOP_REGISTER_I)
        else $error("peripheral clock wrong");
    AST_DEEP_PERIPH_OFF: assert property (SLEEPING_O && SLEEP_MODE_O != 3'h0
        |-> PERIPH_CLK_EN_O == '0) else $error("peripheral clock in deep sleep");
    AST_CMP_POWER: assert property (COMPARATOR_POWER_O == !COMPARATOR_OFF_BIT_I)
        else $error("comparator power wrong");
    AST_RESET_FIRST: assert property (WAKE_RESET_O |-> !WAKE_IRQ_O)
        else $error("both wake kinds at once");
    AST_OSC_RESTART: assert property ($fell(SLEEPING_O) |-> MAIN_OSC_EN_O)
        else $error("oscillator off during restart");
    COV_IRQ_WAKE: cover property (WAKE_IRQ_O);
    COV_RESET_WAKE: cover property (WAKE_RESET_O);
    COV_PD: cover property (SLEEPING_O && SLEEP_MODE_O == 3'h2);
endmodule // sleep_ctl_sva
bind sleep_ctl sleep_ctl_sva #(.NPER(NPER)) u_sva (.MCLK_I, .RST_N_I, .HALT_EXEC_I,
    .SLEEP_GATE_BIT_I, .SLEEP_SELECT_FIELD_I, .ADC_ENABLED_I, .COMPARATOR_OFF_BIT_I,
    .CLOCK_STOP_REGISTER_I, .PERIPH_CLK_EN_O, .PERIPH_ACCESS_EN_O, .CPU_CLK_EN_O, .FLASH_CLK_EN_O,
    .IO_CLK_EN_O, .ADC_CLK_EN_O, .ASYNC_TIMER_CLOCK_EN_O, .MAIN_OSC_EN_O, .COMPARATOR_POWER_O,
    .CPU_HALT_O, .ADC_START_O, .WAKE_IRQ_O, .WAKE_RESET_O, .SLEEP_MODE_O, .SLEEPING_O);

/* dv/tb.sv */
/* self-checking bench for the sleep controller.
   assumes the cpu_model partner and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
    localparam int SU = 20;
    logic clk = 0, rst_n = 0, go = 0, gate_b = 1, gie = 1, xtal = 0, adc_en = 1, cmp_off = 0;
    logic on_async = 1, lvl = 1, on_sync = 0;
    logic [1:0] tmask = 2'h1;
    logic [2:0] sel_b = 3'h0;
    logic [7:0] stop = 8'h00;
    logic [15:0] src = 16'h0000;
    wire halt, gate, cmp_pwr, hold, adc_go, w_irq, w_rst, asleep;
    wire [2:0] sel, mode;
    wire [6:0] en;
    wire [7:0] pclk, pacc;
    int fails = 0, n_tests = 0;
    bit adc_seen, rst_seen, irq_seen;
    cpu_model u_cpu (.clk_i(clk), .go_i(go), .gate_i(gate_b), .sel_i(sel_b), .halt_o(halt),
        .gate_o(gate), .sel_o(sel));
    sleep_ctl #(.NPER(8), .STARTUP_CYC(16'h0014)) u_dut (.MCLK_I(clk), .RST_N_I(rst_n),
        .HALT_EXEC_I(halt), .SLEEP_GATE_BIT_I(gate), .SLEEP_SELECT_FIELD_I(sel),
        .GLOBAL_IRQ_EN_I(gie), .CRYSTAL_SEL_I(xtal), .ADC_ENABLED_I(adc_en),
        .COMPARATOR_OFF_BIT_I(cmp_off), .ASYNC_TIMER_ON_ASYNC_I(on_async),
        .ASYNC_TIMER_ON_SYNC_I(on_sync), .ASYNC_TIMER_IRQ_MASK_I(tmask), .CLOCK_STOP_REGISTER_I(stop),
        .ANY_RESET_I(src[10]), .ADC_DONE_IRQ_I(src[0]), .WDT_IRQ_I(src[1]), .TWI_IRQ_I(src[2]),
        .TWI_ADDR_MATCH_I(src[3]), .ASYNC_TIMER_EVT_I(src[5:4]), .STORE_READY_IRQ_I(src[6]),
        .UPPER_EXTERNAL_IRQS_I({3'h0, src[15]}), .UPPER_EXT_LEVEL_MODE_I({3'h0, lvl}),
        .LOWER_EXTERNAL_IRQS_I(src[14:11]), .PIN_CHANGE_IRQ_I(src[8]), .COMPARATOR_IRQ_I(src[9]),
        .OTHER_IO_IRQ_I(src[7]), .CPU_CLK_EN_O(en[6]), .FLASH_CLK_EN_O(en[5]),
        .IO_CLK_EN_O(en[4]), .ADC_CLK_EN_O(en[3]), .ASYNC_TIMER_CLOCK_EN_O(en[2]),
        .MAIN_OSC_EN_O(en[1]), .TIMER_OSC_EN_O(en[0]), .PERIPH_CLK_EN_O(pclk),
        .PERIPH_ACCESS_EN_O(pacc), .COMPARATOR_POWER_O(cmp_pwr), .CPU_HALT_O(hold),
        .ADC_START_O(adc_go), .WAKE_IRQ_O(w_irq), .WAKE_RESET_O(w_rst), .SLEEP_MODE_O(mode),
        .SLEEPING_O(asleep));
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        if (adc_go === 1'b1) adc_seen = 1;
        if (w_rst === 1'b1) rst_seen = 1;
        if (w_irq === 1'b1) irq_seen = 1;
    end
    task automatic close_out;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic enter(input logic [2:0] m, input logic ok);
        sel_b = m;
        adc_seen = 0;
        @(negedge clk) go <= 1'b1;
        @(negedge clk) go <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK(asleep, ok)
        if (ok) `CHK(mode, m)
    endtask
    task automatic wake(input int i, input int n);
        int c;
        c = 0;
        irq_seen = 0;
        src[i] = 1'b1; // level held until the core is released
        while (hold !== 1'b0 && c < 200) begin
            @(negedge clk);
            c++;
        end
        src[i] = 1'b0;
        `CHK(c >= n + 4 && c <= n + 12, 1'b1)
        `CHK(irq_seen, 1'b1)
        repeat (2) @(negedge clk);
    endtask
    task automatic nowake(input int i);
        src[i] = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(asleep, 1'b1)
        src[i] = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic s_idle;
        stop = 8'ha5; // peripherals assumed idle before their clocks stop
        enter(3'h0, 1'b1);
        `CHK(en[6:3], 4'h3)
        `CHK(adc_seen, 1'b1)
        `CHK(pclk, 8'h5a)
        `CHK(pacc, 8'h5a)
        cmp_off = 1'b1;
        @(negedge clk);
        `CHK(cmp_pwr, 1'b0)
        cmp_off = 1'b0;
        wake(7, 6);
        stop = 8'h00;
        @(negedge clk);
        `CHK(pacc, 8'hff)
    endtask
    task automatic s_adc;
        enter(3'h1, 1'b1);
        `CHK(en[6:3], 4'h1)
        `CHK(adc_seen, 1'b1)
        nowake(7);
        nowake(9);
        wake(0, 6);
    endtask
    task automatic s_pd;
        enter(3'h2, 1'b1);
        `CHK(en[6:1], 6'h00)
        `CHK(adc_seen, 1'b0)
        nowake(0);
        lvl = 1'b0;
        nowake(15);
        lvl = 1'b1;
        wake(11, SU);
    endtask
    task automatic s_ps;
        gie = 1'b0;
        enter(3'h3, 1'b1);
        `CHK(en[2:0], 3'h5)
        on_sync = 1'b1;
        @(negedge clk);
        `CHK(en[1], 1'b1)
        on_sync = 1'b0;
        nowake(4);
        gie = 1'b1;
        nowake(5);
        tmask = 2'h2;
        nowake(4);
        tmask = 2'h1;
        wake(4, SU);
    endtask
    task automatic s_stby;
        enter(3'h6, 1'b0);
        xtal = 1'b1;
        enter(3'h6, 1'b1);
        `CHK(en[4:1], 4'h1)
        wake(3, 6);
        enter(3'h7, 1'b1);
        `CHK(en[2:1], 2'h3)
        wake(4, 6);
    endtask
    task automatic s_refuse;
        enter(3'h4, 1'b0);
        enter(3'h5, 1'b0);
        gate_b = 1'b0;
        enter(3'h0, 1'b0);
        gate_b = 1'b1;
        @(negedge clk);
    endtask
    task automatic s_rst;
        enter(3'h0, 1'b1);
        rst_seen = 0;
        irq_seen = 0;
        src[10] = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(rst_seen, 1'b1)
        `CHK(asleep, 1'b0)
        `CHK(irq_seen, 1'b0)
        src[10] = 1'b0;
        repeat (40) @(negedge clk);
        `CHK(hold, 1'b0)
        enter(3'h2, 1'b1);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK({asleep, hold, mode}, 5'h00)
        `CHK(en, {6'h3f, on_async})
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK(en, {6'h3f, on_async})
        s_idle();
        s_adc();
        s_pd();
        s_ps();
        s_stby();
        s_refuse();
        s_rst();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule // tb

/* src/sleep_ctl.v */
/*
 * sleep-mode controller: decodes the sleep select field, gates the clock
 * domains and oscillators, gathers wake sources and times the wake-up.
 * assumes the cpu core, interrupt logic and peripherals sit on MCLK_I and
 * that wake sources arrive from outside the domain (they are synchronised).
 */
`timescale 1ns/1ps
`include "sleep_ctl_defs.vh"
module sleep_ctl #(
    parameter NPER = 8,
    parameter [`CNT_W-1:0] STARTUP_CYC = `STARTUP_DEFAULT
) (
    // clock and reset
    input wire MCLK_I,
    input wire RST_N_I,
    // cpu side
    input wire HALT_EXEC_I,
    input wire SLEEP_GATE_BIT_I,
    input wire [2:0] SLEEP_SELECT_FIELD_I,
    input wire GLOBAL_IRQ_EN_I,
    input wire CRYSTAL_SEL_I,
    input wire ADC_ENABLED_I,
    input wire COMPARATOR_OFF_BIT_I,
    input wire ASYNC_TIMER_ON_ASYNC_I,
    input wire ASYNC_TIMER_ON_SYNC_I,
    input wire [1:0] ASYNC_TIMER_IRQ_MASK_I,
    input wire [NPER-1:0] CLOCK_STOP_REGISTER_I,
    // wake sources
    input wire ANY_RESET_I,
    input wire ADC_DONE_IRQ_I,
    input wire WDT_IRQ_I,
    input wire TWI_IRQ_I,
    input wire TWI_ADDR_MATCH_I,
    input wire [1:0] ASYNC_TIMER_EVT_I,
    input wire STORE_READY_IRQ_I,
    input wire [3:0] UPPER_EXTERNAL_IRQS_I,
    input wire [3:0] UPPER_EXT_LEVEL_MODE_I,
    input wire [3:0] LOWER_EXTERNAL_IRQS_I,
    input wire PIN_CHANGE_IRQ_I,
    input wire COMPARATOR_IRQ_I,
    input wire OTHER_IO_IRQ_I,
    // clock and oscillator enables
    output wire CPU_CLK_EN_O,
    output wire FLASH_CLK_EN_O,
    output wire IO_CLK_EN_O,
    output wire ADC_CLK_EN_O,
    output wire ASYNC_TIMER_CLOCK_EN_O,
    output wire MAIN_OSC_EN_O,
    output wire TIMER_OSC_EN_O,
    output wire [NPER-1:0] PERIPH_CLK_EN_O,
    output wire [NPER-1:0] PERIPH_ACCESS_EN_O,
    output wire COMPARATOR_POWER_O,
    // cpu status
    output reg CPU_HALT_O,
    output reg ADC_START_O,
    output reg WAKE_IRQ_O,
    output reg WAKE_RESET_O,
    output reg [2:0] SLEEP_MODE_O,
    output reg SLEEPING_O
);
    // ------------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------------
    localparam [3:0] ST_ACTIVE = 4'h1;
    localparam [3:0] ST_SLEEP = 4'h2;
    localparam [3:0] ST_START = 4'h4;
    localparam [3:0] ST_HOLD = 4'h8;

    // ------------------------------------------------------------------
    // wake source synchronisers
    // ------------------------------------------------------------------
    localparam SW = 23;
    wire [SW-1:0] raw = {ANY_RESET_I, ADC_DONE_IRQ_I, WDT_IRQ_I, TWI_IRQ_I,
        TWI_ADDR_MATCH_I, ASYNC_TIMER_EVT_I, STORE_READY_IRQ_I,
        UPPER_EXTERNAL_IRQS_I, LOWER_EXTERNAL_IRQS_I, PIN_CHANGE_IRQ_I,
        COMPARATOR_IRQ_I, OTHER_IO_IRQ_I, UPPER_EXT_LEVEL_MODE_I};
    reg [SW-1:0] sync1;
    reg [SW-1:0] sync2;
    always @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            sync1 <= {SW{1'b0}};
            sync2 <= {SW{1'b0}};
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    wire s_rst = sync2[22];
    wire s_adc = sync2[21];
    wire s_wdt = sync2[20];
    wire s_twi = sync2[19];
    wire s_twi_match = sync2[18];
    wire [1:0] s_tmr = sync2[17:16];
    wire s_store = sync2[15];
    wire [3:0] s_upper = sync2[14:11];
    wire [3:0] s_lower = sync2[10:7];
    wire s_pc = sync2[6];
    wire s_cmp = sync2[5];
    wire s_other = sync2[4];
    wire [3:0] s_upper_lvl = sync2[3:0];

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    reg [3:0] state;
    reg [3:0] next_state;
    wire [2:0] sel = SLEEP_SELECT_FIELD_I;
    // standby codes only make sense with a crystal, reserved codes never
    wire sel_ok = !(sel == `SLEEP_RSVD_A || sel == `SLEEP_RSVD_B) &&
                  !((sel == `SLEEP_STANDBY || sel == `SLEEP_EXT_STBY) &&
                    !CRYSTAL_SEL_I);
    wire enter = HALT_EXEC_I && SLEEP_GATE_BIT_I && sel_ok &&
                 (state == ST_ACTIVE);
    wire [2:0] m = SLEEP_MODE_O;
    // oscillators restart as the wake is taken, so the count times a running clock
    wire asleep = (state == ST_SLEEP);
    wire m_idle = (m == `SLEEP_IDLE);
    wire m_adcq = (m == `SLEEP_ADC_QUIET);
    wire m_save = (m == `SLEEP_PWR_SAVE) || (m == `SLEEP_EXT_STBY);
    wire m_osc = (m == `SLEEP_STANDBY) || (m == `SLEEP_EXT_STBY);

    // ------------------------------------------------------------------
    // wake source selection per mode
    // ------------------------------------------------------------------
    // upper lines wake the quiet and deep modes only when set to level mode
    wire [3:0] upper_lvl = s_upper & s_upper_lvl;
    wire tmr_evt = |(s_tmr & ASYNC_TIMER_IRQ_MASK_I) && GLOBAL_IRQ_EN_I;
    wire deep_wake = s_twi_match || (|upper_lvl) || (|s_lower) || s_pc || s_wdt;
    reg wake_irq;
    always @* begin
        wake_irq = 1'b0;
        if (m_idle) begin
            wake_irq = s_adc || s_wdt || s_twi || s_twi_match || tmr_evt ||
                       s_store || (|s_upper) || (|s_lower) || s_pc || s_other ||
                       (s_cmp && !COMPARATOR_OFF_BIT_I);
        end else if (m_adcq) begin
            wake_irq = s_adc || s_wdt || s_twi || tmr_evt || s_store ||
                       (|upper_lvl) || s_pc;
        end else if (m_save) begin
            wake_irq = deep_wake || tmr_evt;
        end else begin
            wake_irq = deep_wake;
        end
    end

    // ------------------------------------------------------------------
    // wake timing
    // ------------------------------------------------------------------
    // oscillator stays up in idle, adc quiet and standby modes: short restart
    wire need_startup = !(m_idle || m_adcq || m_osc);
    localparam [`CNT_W-1:0] SHORT_CYC = `OSC_RESTART_CYC;
    localparam [`CNT_W-1:0] HOLD_CYC = `WAKE_HOLD_CYC;
    wire [`CNT_W-1:0] restart_cyc = need_startup ? STARTUP_CYC :
                                    SHORT_CYC;
    reg load;
    reg [`CNT_W-1:0] load_val;
    wire done;
    wake_delay #(
        .W(`CNT_W)
    ) u_delay (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .load_i(load),
        .count_i(load_val),
        .done_o(done)
    );

    // ------------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------------
    always @* begin
        next_state = state;
        load = 1'b0;
        load_val = restart_cyc;
        case (state)
            ST_ACTIVE: begin
                if (enter) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (s_rst || wake_irq) begin
                    next_state = ST_START;
                    load = 1'b1;
                end
            end
            ST_START: begin
                if (done) begin
                    next_state = ST_HOLD;
                    load = 1'b1;
                    load_val = HOLD_CYC;
                end
            end
            ST_HOLD: begin
                if (done) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // only state flags here: register file and sram are never touched
    always @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state <= ST_ACTIVE;
            SLEEP_MODE_O <= `SLEEP_IDLE;
            SLEEPING_O <= 1'b0;
            CPU_HALT_O <= 1'b0;
            ADC_START_O <= 1'b0;
            WAKE_IRQ_O <= 1'b0;
            WAKE_RESET_O <= 1'b0;
        end else begin
            state <= next_state;
            ADC_START_O <= 1'b0;
            WAKE_IRQ_O <= 1'b0;
            WAKE_RESET_O <= 1'b0;
            if (enter) begin
                SLEEP_MODE_O <= sel;
                SLEEPING_O <= 1'b1;
                CPU_HALT_O <= 1'b1;
                ADC_START_O <= ADC_ENABLED_I &&
                    (sel == `SLEEP_IDLE || sel == `SLEEP_ADC_QUIET);
            end
            if (state == ST_SLEEP && (s_rst || wake_irq)) begin
                SLEEPING_O <= 1'b0;
                // reset wins: cpu restarts from the vector, not after halt
                WAKE_RESET_O <= s_rst;
                WAKE_IRQ_O <= !s_rst;
            end
            if (state == ST_HOLD && done) begin
                CPU_HALT_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // clock gating
    // ------------------------------------------------------------------
    // gates drop while asleep and stay down until the restart count is over; cpu and flash gates stay down through the hold count too
    wire off = (state == ST_SLEEP) || (state == ST_START);
    assign CPU_CLK_EN_O = !off && state != ST_HOLD;
    assign FLASH_CLK_EN_O = CPU_CLK_EN_O;
    assign IO_CLK_EN_O = !off || m_idle;
    assign ADC_CLK_EN_O = !off || m_idle || m_adcq;
    assign ASYNC_TIMER_CLOCK_EN_O = !off || m_idle || m_adcq ||
                                    (m_save && ASYNC_TIMER_ON_ASYNC_I);
    assign MAIN_OSC_EN_O = !asleep || m_idle || m_adcq || m_osc ||
                           (m_save && ASYNC_TIMER_ON_SYNC_I);
    assign TIMER_OSC_EN_O = ASYNC_TIMER_ON_ASYNC_I &&
                            (!asleep || m_idle || m_adcq || m_save);
    assign COMPARATOR_POWER_O = !COMPARATOR_OFF_BIT_I;

    // ------------------------------------------------------------------
    // per-peripheral clock stop
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NPER; i = i + 1) begin : g_per
            // stopping the clock freezes state, so clearing resumes it as-is
            assign PERIPH_CLK_EN_O[i] = !CLOCK_STOP_REGISTER_I[i] &&
                                        IO_CLK_EN_O;
            assign PERIPH_ACCESS_EN_O[i] = !CLOCK_STOP_REGISTER_I[i];
        end
    endgenerate
endmodule // sleep_ctl

/* src/sleep_ctl_defs.vh */
/*
 * constants for the sleep-mode clock gating block: mode codes, timing counts.
 * assumes a 10 MHz system clock and a cpu core that pulses a halt strobe.
 */
// Overview of operation
// - sleep needs gate bit plus halt instruction
// - code 000 idle stops cpu, flash
// - code 001 stops io, cpu, flash clocks
// - adc quiet sleep wakes on listed sources
// - code 010 power-down stops all generated clocks
// - power-down wakes only on listed sources
// - power-down wake waits fuse start-up time
// - code 011 power-save keeps async timer waking
// - power-save stops unused timer clock sources
// - code 110 standby keeps oscillator, six cycles
// - code 111 extended standby, six cycle wake
// - interrupt wake holds cpu four extra cycles
// - sleep leaves register file, sram intact
// - reset during sleep restarts at vector
// - idle or adc sleep starts conversion
// - clock-stop bit freezes peripheral, blocks access
// - clearing clock-stop resumes frozen state
// - clock-stop acts only active and idle
// - comparator off bit removes idle wake
// - codes 100 and 101 are reserved
`ifndef SLEEP_CTL_DEFS_VH
`define SLEEP_CTL_DEFS_VH

`define SLEEP_IDLE      3'h0
`define SLEEP_ADC_QUIET 3'h1
`define SLEEP_PWR_DOWN  3'h2
`define SLEEP_PWR_SAVE  3'h3
`define SLEEP_RSVD_A    3'h4
`define SLEEP_RSVD_B    3'h5
`define SLEEP_STANDBY   3'h6
`define SLEEP_EXT_STBY  3'h7

`define OSC_RESTART_CYC 6
`define WAKE_HOLD_CYC   4
`define STARTUP_DEFAULT 16
`define CNT_W           16

`endif

/* src/wake_delay.v */
/*
 * wake delay counter: loads a cycle count and raises done when it runs out.
 * assumes load is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module wake_delay #(
    parameter W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // control
    input wire load_i,
    input wire [W-1:0] count_i,
    // status
    output reg done_o
);
    reg [W-1:0] cnt;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt <= {W{1'b0}};
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt <= count_i;
            done_o <= 1'b0;
        end else if (cnt != {W{1'b0}}) begin
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            done_o <= (cnt == {{(W-1){1'b0}}, 1'b1});
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule // wake_delay
